//--- hw/adc_conv_ctrl.sv
// conversion sequencing and result readout of the 16-bit converter
// ***************************
// ***************************
`timescale 1ns/1ps
module adc_conv_ctrl
  import adc_timing_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // conversion control pins
  input wire logic i_convert_start_n,
  input wire logic i_conv_reset,
  input wire logic i_fast_mode,
  input wire logic i_normal_sel_n,
  output logic o_busy,
  output logic o_wideband,
  // converter core result
  input wire logic [15:0] i_sample_data,
  // parallel port
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  output logic [15:0] o_data,
  output logic o_data_oe,
  // serial master port
  input wire logic i_serial_mode,
  input wire logic i_read_after,
  input wire logic [1:0] i_serial_clock_divider,
  output logic o_sync,
  output logic o_sync_oe,
  output logic o_sclk,
  output logic o_sclk_oe,
  output logic o_serial_data_out,
  output logic o_sdo_oe
);

  // ***************************
  // pin synchronisers
  // ***************************
  logic [PIN_W-1:0] pin_raw, s1_q, s2_q, s3_q, pin_q, pin_d, prev_q;
  logic start_fall, rst_fall, parallel, rdc, rac;

  assign pin_raw = {i_serial_clock_divider, i_read_after, i_serial_mode, i_normal_sel_n,
                    i_fast_mode, i_rd_n, i_cs_n, i_conv_reset, i_convert_start_n};

  always_comb begin
    pin_d = pin_q;
    for (int b = 0; b < PIN_W; b++) begin
      if (s2_q[b] == s3_q[b]) begin
        pin_d[b] = s3_q[b];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_q <= PIN_RST_VAL;
      s2_q <= PIN_RST_VAL;
      s3_q <= PIN_RST_VAL;
      pin_q <= PIN_RST_VAL;
      prev_q <= PIN_RST_VAL;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
      prev_q <= pin_q;
    end
  end

  assign start_fall = prev_q[PIN_START] && !pin_q[PIN_START];
  assign rst_fall = prev_q[PIN_CRST] && !pin_q[PIN_CRST];
  assign parallel = !pin_q[PIN_SERIAL];
  assign rdc = pin_q[PIN_SERIAL] && !pin_q[PIN_RAC];
  assign rac = pin_q[PIN_SERIAL] && pin_q[PIN_RAC];
  assign o_wideband = pin_q[PIN_FAST] && pin_q[PIN_NORMAL_N];

  // ***************************
  // fifo
  // ***************************
  result_fifo_if #(.W(RESULT_W)) f ();

  result_fifo #(.W(RESULT_W), .DEPTH(DEPTH)) u_fifo (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .f(f.store)
  );

  // ***************************
  // conversion sequencer
  // ***************************
  conv_state_t st_q, st_d;
  logic [7:0] w_q, w_d, e_q, e_d;
  logic fast_q, fast_d, busy_q;
  logic [15:0] res_q, res_d;
  logic [7:0] work, sync_rdc, sync_rac;
  logic out_done, fin_q, fin_d, frame_go;

  // wideband fast uses the same counts as plain fast
  assign work = fast_q ? 8'(CONV_FAST_CYC) : 8'(CONV_NORM_CYC);
  assign sync_rdc = fast_q ? 8'(SYNC_RDC_FAST_CYC) : 8'(SYNC_RDC_NORM_CYC);
  assign sync_rac = fast_q ? 8'(SYNC_RAC_FAST_CYC) : 8'(SYNC_RAC_NORM_CYC);

  assign f.wdata = res_q;
  assign f.wvalid = (st_q == S_STORE);

  always_comb begin
    st_d = st_q;
    w_d = w_q;
    e_d = (e_q != 8'hFF) ? e_q + 8'h01 : e_q;
    fast_d = fast_q;
    res_d = res_q;
    case (st_q)
      S_IDLE: begin
        if (start_fall) begin
          st_d = S_CONV;
          w_d = 8'h00;
          e_d = 8'h00;
          fast_d = pin_q[PIN_FAST];
        end
      end
      S_RSTHOLD: begin
        if (w_q >= 8'(RST_BUSY_CYC - 1)) begin
          st_d = S_IDLE;
        end else begin
          w_d = w_q + 8'h01;
        end
      end
      S_CONV: begin
        if (w_q >= work - 8'h01) begin
          st_d = S_STORE;
          res_d = i_sample_data;
        end else begin
          w_d = w_q + 8'h01;
        end
      end
      S_STORE: begin
        // a full fifo stalls the sequencer with busy held high
        if (f.wready) begin
          st_d = S_OUT;
        end
      end
      S_OUT: begin
        if (out_done) begin
          st_d = S_TAIL;
          w_d = 8'h00;
        end
      end
      S_TAIL: begin
        if (w_q >= 8'(EOC_BUSY_CYC - 1)) begin
          st_d = S_IDLE;
        end else begin
          w_d = w_q + 8'h01;
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
    if (rst_fall) begin
      st_d = S_RSTHOLD;
      w_d = 8'h00;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= S_IDLE;
      w_q <= 8'h00;
      e_q <= 8'h00;
      fast_q <= 1'b0;
      res_q <= RESULT_RST;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      w_q <= w_d;
      e_q <= e_d;
      fast_q <= fast_d;
      res_q <= res_d;
      busy_q <= (st_d != S_IDLE);
    end
  end

  assign o_busy = busy_q;

  // ***************************
  // readout: parallel latch and serial master frame
  // ***************************
  frame_state_t fr_q, fr_d;
  logic [3:0] h_q, h_d, half_q, half_d;
  logic [4:0] n_q, n_d;
  logic sclk_q, sclk_d, pop;
  logic [1:0] div_sel;
  logic [15:0] sh_q, sh_d, pdata_q, pdata_d;

  // parallel: loaded before leaving S_OUT, so data precedes busy fall
  // rac: busy stays high until the frame has ended
  assign out_done = parallel ? !f.rvalid : (rac ? fin_q : 1'b1);
  assign frame_go = (fr_q == FR_IDLE) && f.rvalid &&
                    ((rdc && st_q == S_CONV && e_q == sync_rdc) ||
                     (rac && st_q == S_OUT && e_q >= sync_rac));

  always_comb begin
    fr_d = fr_q;
    h_d = h_q;
    n_d = n_q;
    half_d = half_q;
    sclk_d = sclk_q;
    sh_d = sh_q;
    fin_d = 1'b0;
    pop = 1'b0;
    pdata_d = pdata_q;
    if (parallel && f.rvalid) begin
      pop = 1'b1;
      pdata_d = f.rdata;
    end
    case (fr_q)
      FR_IDLE: begin
        if (frame_go) begin
          pop = 1'b1;
          sh_d = f.rdata;
          fr_d = FR_LEAD;
          h_d = 4'h0;
          n_d = 5'h00;
          half_d = rac ? (4'h1 << div_sel) : 4'h1;
        end
      end
      FR_LEAD: begin
        if (h_q >= half_q - 4'h1) begin
          h_d = 4'h0;
          fr_d = FR_SHIFT;
        end else begin
          h_d = h_q + 4'h1;
        end
      end
      FR_SHIFT: begin
        if (h_q >= half_q - 4'h1) begin
          h_d = 4'h0;
          sclk_d = !sclk_q;
          if (sclk_q) begin
            sh_d = {sh_q[14:0], 1'b0};
            n_d = n_q + 5'h01;
            if (n_q == 5'(RESULT_W - 1)) begin
              fr_d = FR_IDLE;
              fin_d = 1'b1;
            end
          end
        end else begin
          h_d = h_q + 4'h1;
        end
      end
      default: begin
        fr_d = FR_IDLE;
      end
    endcase
  end

  assign div_sel = pin_q[PIN_DIV +: 2];

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fr_q <= FR_IDLE;
      h_q <= 4'h0;
      n_q <= 5'h00;
      half_q <= 4'h1;
      sclk_q <= 1'b0;
      sh_q <= RESULT_RST;
      fin_q <= 1'b0;
      pdata_q <= RESULT_RST;
    end else begin
      fr_q <= fr_d;
      h_q <= h_d;
      n_q <= n_d;
      half_q <= half_d;
      sclk_q <= sclk_d;
      sh_q <= sh_d;
      fin_q <= fin_d;
      pdata_q <= pdata_d;
    end
  end

  assign f.rready = pop;
  assign o_data = pdata_q;
  assign o_data_oe = parallel && !pin_q[PIN_CS] && !pin_q[PIN_RD];
  assign o_sync = (fr_q != FR_IDLE);
  assign o_sclk = sclk_q;
  assign o_serial_data_out = sh_q[15];
  assign o_sync_oe = pin_q[PIN_SERIAL] && !pin_q[PIN_CS];
  assign o_sclk_oe = pin_q[PIN_SERIAL] && !pin_q[PIN_CS];
  assign o_sdo_oe = pin_q[PIN_SERIAL] && !pin_q[PIN_CS];

  // ***************************
  // assertions
  // ***************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  sequence conv_fast_s;
    (st_q == S_CONV) [*4] ##1 (st_q == S_STORE);
  endsequence
  sequence conv_norm_s;
    (st_q == S_CONV) [*6] ##1 (st_q == S_STORE);
  endsequence

  a_busy_rise: assert property (st_q == S_IDLE && start_fall |=> o_busy)
    else $error("busy did not rise after start");
  a_conv_fast: assert property (st_q == S_IDLE && start_fall && !rst_fall && pin_q[PIN_FAST]
    |=> conv_fast_s)
    else $error("fast conversion length wrong");
  a_conv_norm: assert property (st_q == S_IDLE && start_fall && !rst_fall && !pin_q[PIN_FAST]
    |=> conv_norm_s)
    else $error("normal conversion length wrong");
  a_reset_hold: assert property (rst_fall |=> o_busy [*8] ##1 o_busy [*2] ##1 !o_busy)
    else $error("busy not held after conversion reset");
  a_tail_gap: assert property ($fell(o_busy) && $past(st_q != S_RSTHOLD)
    |-> $past(st_q == S_TAIL))
    else $error("busy fell without end gap");
  a_data_latch: assert property ($fell(o_busy) && parallel && $past(st_q == S_TAIL)
    |-> o_data == res_q && $past(o_data) == res_q)
    else $error("parallel data not ready before busy fall");
  a_bus_data: assert property (parallel && !pin_q[PIN_CS] && !pin_q[PIN_RD] |-> o_data_oe)
    else $error("bus request not answered");
  a_serial_hiz: assert property (pin_q[PIN_CS] |-> !o_sync_oe && !o_sclk_oe && !o_sdo_oe)
    else $error("serial outputs driven with chip select high");
  a_rac_busy: assert property (rac && fin_q && st_q == S_OUT && !rst_fall
    |=> st_q == S_TAIL ##1 !o_busy)
    else $error("busy did not follow end of frame");
  a_sclk_fast: assert property ($rose(o_sclk) && half_q == 4'h1 |=> $fell(o_sclk))
    else $error("fastest serial clock half period wrong");
  a_sclk_slow: assert property ($rose(o_sclk) && half_q == 4'h8
    |=> o_sclk [*7] ##1 !o_sclk)
    else $error("slowest serial clock half period wrong");

endmodule

//--- hw/adc_timing_pkg.sv
// constants, timing counts and state types of the converter control block
package adc_timing_pkg;

  // ***************************
  // clock and cycle conversion
  // ***************************
  localparam int CLK_NS = 50;

  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_max(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ***************************
  // documented times in ns
  // ***************************
  localparam int T_START_BUSY_NS = 23;
  localparam int T_CONV_FAST_NS = 360;
  localparam int T_CONV_NORM_NS = 485;
  localparam int T_EOC_BUSY_NS = 10;
  localparam int T_RST_BUSY_NS = 500;
  localparam int T_BUS_DATA_NS = 20;
  localparam int T_SYNC_RDC_FAST_NS = 15;
  localparam int T_SYNC_RDC_NORM_NS = 135;
  localparam int T_SYNC_RAC_FAST_NS = 375;
  localparam int T_SYNC_RAC_NORM_NS = 500;
  localparam int T_SYNC_BUSY_NS = 13;
  localparam int T_HIZ_NS = 10;

  // ***************************
  // cycle counts
  // ***************************
  localparam int START_BUSY_CYC = cyc_max(T_START_BUSY_NS);
  localparam int CONV_OVERHEAD_CYC = 3;
  localparam int CONV_FAST_CYC = cyc_max(T_CONV_FAST_NS) - CONV_OVERHEAD_CYC;
  localparam int CONV_NORM_CYC = cyc_max(T_CONV_NORM_NS) - CONV_OVERHEAD_CYC;
  localparam int EOC_BUSY_CYC = cyc_min(T_EOC_BUSY_NS);
  localparam int RST_BUSY_CYC = cyc_min(T_RST_BUSY_NS);
  localparam int SYNC_RDC_FAST_CYC = cyc_max(T_SYNC_RDC_FAST_NS);
  localparam int SYNC_RDC_NORM_CYC = cyc_max(T_SYNC_RDC_NORM_NS);
  localparam int SYNC_RAC_FAST_CYC = cyc_max(T_SYNC_RAC_FAST_NS);
  localparam int SYNC_RAC_NORM_CYC = cyc_max(T_SYNC_RAC_NORM_NS);
  localparam int SYNC_BUSY_CYC = cyc_max(T_SYNC_BUSY_NS);

  // ***************************
  // data path
  // ***************************
  localparam int RESULT_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  // ***************************
  // pin vector layout
  // ***************************
  localparam int PIN_W = 10;
  localparam int PIN_START = 0;
  localparam int PIN_CRST = 1;
  localparam int PIN_CS = 2;
  localparam int PIN_RD = 3;
  localparam int PIN_FAST = 4;
  localparam int PIN_NORMAL_N = 5;
  localparam int PIN_SERIAL = 6;
  localparam int PIN_RAC = 7;
  localparam int PIN_DIV = 8;
  localparam logic [9:0] PIN_RST_VAL = 10'h02D;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_RSTHOLD = 6'h02,
    S_CONV = 6'h04,
    S_STORE = 6'h08,
    S_OUT = 6'h10,
    S_TAIL = 6'h20
  } conv_state_t;

  typedef enum logic [2:0] {
    FR_IDLE = 3'h1,
    FR_LEAD = 3'h2,
    FR_SHIFT = 3'h4
  } frame_state_t;

endpackage

//--- hw/result_fifo.sv
// result fifo with valid/ready on both sides
`timescale 1ns/1ps
module result_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // fifo ports
  result_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign f.wready = (cnt_q != (AW+1)'(DEPTH));
  assign f.rvalid = (cnt_q != '0);
  assign f.rdata = mem_q[rp_q];

  always_comb begin
    push = f.wvalid && f.wready;
    pop = f.rready && f.rvalid;
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_q[wp_q] <= f.wdata;
    end
  end
endmodule

//--- hw/result_fifo_if.sv
// handshake carrier between the control block and its result fifo
`timescale 1ns/1ps
interface result_fifo_if #(parameter int W = 16);
  logic [W-1:0] wdata;
  logic wvalid;
  logic wready;
  logic [W-1:0] rdata;
  logic rvalid;
  logic rready;
  modport user (output wdata, output wvalid, output rready,
                input wready, input rdata, input rvalid);
  modport store (input wdata, input wvalid, input rready,
                 output wready, output rdata, output rvalid);
endinterface

//--- sim/host_model.sv
// host controller model that issues conversions and times busy
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic i_clock,
  // device status
  input wire logic i_busy,
  // conversion control
  output logic o_convert_start_n,
  output logic o_fast_mode,
  output logic o_normal_sel_n
);
  int rise_cyc;
  int high_cyc;
  logic timed_out;

  initial begin
    o_convert_start_n = 1'b1;
    o_fast_mode = 1'b1;
    o_normal_sel_n = 1'b0;
    timed_out = 1'b0;
  end

  // ***************************
  // one conversion with a bounded wait on busy
  // ***************************
  task automatic convert(input logic fast, input logic norm_n);
    o_fast_mode <= fast;
    o_normal_sel_n <= norm_n;
    repeat (6) @(posedge i_clock);
    o_convert_start_n <= 1'b0;
    rise_cyc = 0;
    high_cyc = 0;
    for (int k = 0; k < 600 && !(rise_cyc > 0 && !i_busy); k++) begin
      @(posedge i_clock);
      if (k == 1) o_convert_start_n <= 1'b1;
      if (i_busy && rise_cyc == 0) rise_cyc = k + 1;
      if (i_busy) high_cyc++;
    end
    // give up rather than hang if busy never falls
    timed_out = i_busy || rise_cyc == 0;
    // acquisition time and start spacing, far inside the fast-mode maximum gap
    repeat (fast ? 3 : 4) @(posedge i_clock);
  endtask
endmodule

//--- sim/tb.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
module tb;
  import adc_timing_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_conv_reset = 1'b0;
  logic [15:0] i_sample_data = 16'h0000;
  logic i_cs_n = 1'b1;
  logic i_rd_n = 1'b1;
  logic i_serial_mode = 1'b0;
  logic i_read_after = 1'b0;
  logic [1:0] i_serial_clock_divider = 2'h0;
  logic start_n, fast, norm_n, o_busy, o_wideband, o_data_oe;
  logic o_sync, o_sync_oe, o_sclk, o_sclk_oe, o_sdo, o_sdo_oe;
  logic [15:0] o_data, rx, data_at_fall;
  logic sclk_p = 1'b0, sync_p = 1'b0, busy_p = 1'b0, sync_busy = 1'b0;
  int cyc = 0, n_pulse = 0, per = 0, last_rise = 0, sync_fall = 0, busy_fall = 0;
  int n_fail = 0;
  int cmp_count = 0;

  always #25 i_clock = ~i_clock;

  host_model host_model_i (.i_clock(i_clock), .i_busy(o_busy), .o_convert_start_n(start_n),
    .o_fast_mode(fast), .o_normal_sel_n(norm_n));

  adc_conv_ctrl adc_conv_ctrl_i (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_convert_start_n(start_n), .i_conv_reset(i_conv_reset), .i_fast_mode(fast),
    .i_normal_sel_n(norm_n), .o_busy(o_busy), .o_wideband(o_wideband),
    .i_sample_data(i_sample_data), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .o_data(o_data),
    .o_data_oe(o_data_oe), .i_serial_mode(i_serial_mode), .i_read_after(i_read_after),
    .i_serial_clock_divider(i_serial_clock_divider), .o_sync(o_sync),
    .o_sync_oe(o_sync_oe), .o_sclk(o_sclk), .o_sclk_oe(o_sclk_oe),
    .o_serial_data_out(o_sdo), .o_sdo_oe(o_sdo_oe));

  // ***************************
  // wire monitor and hang guard
  // ***************************
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    sclk_p <= o_sclk;
    sync_p <= o_sync;
    busy_p <= o_busy;
    // data moves on the falling serial clock, so take it on the rise
    if (o_sclk && !sclk_p) begin
      rx <= {rx[14:0], o_sdo};
      n_pulse <= n_pulse + 1;
      per <= cyc - last_rise;
      last_rise <= cyc;
    end
    if (o_sync && !sync_p) sync_busy <= o_busy;
    if (!o_sync && sync_p) sync_fall <= cyc;
    if (!o_busy && busy_p) begin
      busy_fall <= cyc;
      data_at_fall <= o_data;
    end
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  // ***************************
  // shared tasks
  // ***************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic conv(input logic f, input logic nn, input logic [15:0] v);
    i_sample_data <= v;
    host_model_i.convert(f, nn);
    check("busy timeout", 1'b0, host_model_i.timed_out);
  endtask

  task automatic busy_width(output int w);
    w = 0;
    for (int k = 0; k < 12 && !o_busy; k++) @(posedge i_clock);
    while (o_busy && w < 400) begin
      @(posedge i_clock);
      w++;
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ***************************
  // scenarios
  // ***************************
  task automatic t_reset_hold();
    int w;
    busy_width(w);
    check("busy after reset", 0, w);
    i_conv_reset <= 1'b1;
    repeat (6) @(posedge i_clock);
    i_conv_reset <= 1'b0;
    busy_width(w);
    check("busy after restart", RST_BUSY_CYC, w);
    repeat (4) @(posedge i_clock);
  endtask

  task automatic t_modes();
    logic [15:0] v;
    int c;
    int w_wide;
    for (int m = 0; m < 3; m++) begin
      v = 16'hA5C3 ^ 16'(m * 16'h1111);
      c = (m < 2) ? CONV_FAST_CYC : CONV_NORM_CYC;
      conv(m < 2, m == 0, v);
      check("wideband flag", m == 0, o_wideband);
      check("busy rise", 1'b1, host_model_i.rise_cyc <= 6);
      check("busy width", 1'b1, host_model_i.high_cyc > c);
      check("busy bound", 1'b1, host_model_i.high_cyc <= c + 4);
      if (m == 0) w_wide = host_model_i.high_cyc;
      if (m == 1) check("wide equals fast", w_wide, host_model_i.high_cyc);
      check("data at busy fall", v, data_at_fall);
      i_cs_n <= 1'b0;
      i_rd_n <= 1'b0;
      repeat (6) @(posedge i_clock);
      check("bus enable", 1'b1, o_data_oe);
      check("bus data", v, o_data);
      i_cs_n <= 1'b1;
      i_rd_n <= 1'b1;
      repeat (6) @(posedge i_clock);
      check("bus release", 1'b0, o_data_oe);
    end
  endtask

  task automatic t_serial_rac();
    logic [15:0] v;
    int base;
    i_serial_mode <= 1'b1;
    i_read_after <= 1'b1;
    i_cs_n <= 1'b0;
    for (int d = 0; d < 4; d++) begin
      v = 16'h8E31 ^ 16'(d << 4);
      i_serial_clock_divider <= 2'(d);
      base = n_pulse;
      conv(1'b1, 1'b0, v);
      check("rac pulses", 16, n_pulse - base);
      check("rac busy width", SYNC_RAC_FAST_CYC + 3 + (33 << d), host_model_i.high_cyc);
      check("rac word", v, rx);
      check("rac period", 2 << d, per);
      check("sync to busy", 1'b1, busy_fall - sync_fall inside {[1:3]});
      check("rac drive", 3'h7, {o_sync_oe, o_sclk_oe, o_sdo_oe});
    end
  endtask

  task automatic t_serial_rdc();
    int base;
    i_read_after <= 1'b0;
    conv(1'b1, 1'b0, 16'h3C5A);
    base = n_pulse;
    conv(1'b1, 1'b0, 16'hC3A5);
    // the frame of the previous word outlasts busy: let it finish
    repeat (40) @(posedge i_clock);
    check("rdc pulses", 16, n_pulse - base);
    check("rdc word", 16'h3C5A, rx);
    check("rdc period", 2, per);
    check("rdc sync in busy", 1'b1, sync_busy);
    conv(1'b0, 1'b1, 16'h0F0F);
    repeat (40) @(posedge i_clock);
    check("rdc normal word", 16'hC3A5, rx);
  endtask

  task automatic t_float();
    i_cs_n <= 1'b1;
    repeat (6) @(posedge i_clock);
    check("serial float", 3'h0, {o_sync_oe, o_sclk_oe, o_sdo_oe});
  endtask

  initial begin
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    t_reset_hold();
    t_modes();
    t_serial_rac();
    t_serial_rdc();
    t_float();
    results();
  end
endmodule
